// File: cpu_regs_stack.sv
// cpu register set with stack, call/return and fetch sequencing
`timescale 1ns/1ps

// Behaviour
// - the fetch pointer is 16 bits and the working, both offset, frame top and flag registers are 8 bits.
// - reset sets the interrupt mask flag; other registers are cleared only for tidiness and software must set them.
// - interrupt entry writes fetch high, decrements, writes fetch low, decrements, writes flags, decrements.
// - a call pushes only fetch high then low, each followed by a decrement, and saves no flags.
// - every stack address is the page bit above the frame top pointer.
// - a working push writes the working register at the address built from the current frame top.
// - a flags push stores the flag word on the stack.
// - interrupt return increments and loads flags, then fetch low, then fetch high.
// - subroutine return increments and loads fetch low, then increments and loads fetch high.
// - working and flag pulls increment the frame top first and then load the byte there.
// - the fetch pointer is two separately writable bytes that hold the next instruction address.
// - when an instruction ends the next one is fetched from the fetch pointer, which then advances.
// - indexed accesses use the operand address plus the chosen offset register.
// - each offset register can be incremented, decremented, compared and transferred.
// - accepting an interrupt sets the mask flag at once.
// - the stacked break flag is one for a software break and zero for other interrupts.
module cpu_regs_stack
	import cpu_regs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cmd_valid_i,
	input wire cmd_s cmd_i,
	input wire logic stack_page_i,
	input wire logic [7:0] mem_rdata_i,
	output logic cmd_ready_o,
	output logic done_o,
	output mem_s mem_o,
	output logic [7:0] opcode_o,
	output logic opcode_valid_o,
	output logic [7:0] rdata_o,
	output logic rdata_valid_o,
	output logic [7:0] working_reg_o,
	output logic [7:0] first_offset_reg_o,
	output logic [7:0] second_offset_reg_o,
	output logic [7:0] frame_top_ptr_o,
	output logic [7:0] flag_word_o,
	output logic [15:0] fetch_pointer_o
);

	// =====================================================================
	// state
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PUSH,
		ST_PULL,
		ST_WAIT,
		ST_CAP,
		ST_FETCH
	} seq_e;

	seq_e state_r, state_nxt;
	cmd_s cur_r, cur_nxt;
	dest_e dest_r, dest_nxt;
	logic [1:0] step_r, step_nxt;
	logic [7:0] working_reg_r, working_reg_nxt;
	logic [7:0] first_offset_reg_r, first_offset_reg_nxt;
	logic [7:0] second_offset_reg_r, second_offset_reg_nxt;
	logic [7:0] frame_top_ptr_r, frame_top_ptr_nxt;
	logic [7:0] flag_word_r, flag_word_nxt;
	logic [7:0] flag_snap_r, flag_snap_nxt;
	logic [15:0] fetch_pointer_r, fetch_pointer_nxt;
	mem_s mem_r, mem_nxt;
	logic done_r, done_nxt;
	logic ready_r, ready_nxt;
	logic [7:0] opcode_r, opcode_nxt;
	logic opcode_valid_r, opcode_valid_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic rdata_valid_r, rdata_valid_nxt;

	// =====================================================================
	// stack step tables
	function automatic logic [1:0] push_count(input cmd_op_e op);
		unique case (op)
			OP_IRQ, OP_SOFTWARE_BREAK: push_count = IRQ_PUSH_CNT;
			OP_CALL: push_count = CALL_PUSH_CNT;
			default: push_count = ONE_PUSH_CNT;
		endcase
	endfunction

	function automatic logic [1:0] pull_count(input cmd_op_e op);
		unique case (op)
			OP_RETURN_FROM_IRQ: pull_count = RTI_PULL_CNT;
			OP_RETURN_FROM_SUB: pull_count = RTS_PULL_CNT;
			default: pull_count = ONE_PULL_CNT;
		endcase
	endfunction

	function automatic dest_e pull_dest(input cmd_op_e op, input logic [1:0] step);
		unique case (op)
			OP_RETURN_FROM_IRQ: pull_dest = (step == 2'h0) ? DST_FLAGS :
				(step == 2'h1) ? DST_FETCH_LOW : DST_FETCH_HIGH;
			OP_RETURN_FROM_SUB: pull_dest = (step == 2'h0) ? DST_FETCH_LOW : DST_FETCH_HIGH;
			OP_PULL_FLAGS: pull_dest = DST_FLAGS;
			default: pull_dest = DST_WORKING;
		endcase
	endfunction

	// =====================================================================
	// derived wires
	logic [15:0] stack_addr;
	logic [15:0] stack_addr_up;
	logic [7:0] frame_up;
	logic [7:0] stacked_flags;
	logic [7:0] push_byte;
	logic push_last;
	logic pull_last;
	logic [7:0] idx_sel;
	logic use_second;
	idx_op_e idx_op;
	logic [7:0] idx_result;
	idx_flags_s idx_flags;
	logic [15:0] idx_addr;

	// stack address from page bit and frame top
	assign frame_up = frame_top_ptr_r + BYTE_ONE;
	assign stack_addr = {PAGE_PAD, stack_page_i, frame_top_ptr_r};
	assign stack_addr_up = {PAGE_PAD, stack_page_i, frame_up};

	// flags stacked from a snapshot taken at acceptance, break bit from the command
	assign stacked_flags = {flag_snap_r[7:5], (cur_r.op == OP_SOFTWARE_BREAK), flag_snap_r[3:0]};

	// byte written by each push step
	assign push_byte = (cur_r.op == OP_PUSH_WORKING) ? working_reg_r :
		(cur_r.op == OP_PUSH_FLAGS) ? flag_word_r :
		(step_r == 2'h0) ? fetch_pointer_r[15:8] :
		(step_r == 2'h1) ? fetch_pointer_r[7:0] : stacked_flags;
	assign push_last = (step_r == (push_count(cur_r.op) - STEP_ONE));
	assign pull_last = (step_r == (pull_count(cur_r.op) - STEP_ONE));

	// index selection for the index unit
	assign use_second = (cmd_i.sel == SEL_SECOND_OFS);
	assign idx_sel = use_second ? second_offset_reg_r : first_offset_reg_r;
	assign idx_op = (cmd_i.op == OP_INC_IDX) ? IDX_INC : (cmd_i.op == OP_DEC_IDX) ? IDX_DEC :
		(cmd_i.op == OP_CMP_IDX) ? IDX_CMP : IDX_PASS;

	index_unit u_index_unit (
		.idx_i(idx_sel),
		.operand_i(cmd_i.data),
		.base_i(cmd_i.addr),
		.op_i(idx_op),
		.result_o(idx_result),
		.flags_o(idx_flags),
		.addr_o(idx_addr)
	);

	// =====================================================================
	// sequencer next state
	always_comb
	begin
		logic fin;
		logic end_instr;
		fin = 1'b0;
		end_instr = cur_r.end_instr;
		state_nxt = state_r;
		cur_nxt = cur_r;
		dest_nxt = dest_r;
		step_nxt = step_r;
		working_reg_nxt = working_reg_r;
		first_offset_reg_nxt = first_offset_reg_r;
		second_offset_reg_nxt = second_offset_reg_r;
		frame_top_ptr_nxt = frame_top_ptr_r;
		flag_word_nxt = flag_word_r;
		flag_snap_nxt = flag_snap_r;
		fetch_pointer_nxt = fetch_pointer_r;
		mem_nxt = '0;
		done_nxt = 1'b0;
		opcode_nxt = opcode_r;
		opcode_valid_nxt = 1'b0;
		rdata_nxt = rdata_r;
		rdata_valid_nxt = 1'b0;
		unique case (state_r)
			ST_IDLE:
			begin
				end_instr = cmd_i.end_instr;
				if (cmd_valid_i)
				begin
					cur_nxt = cmd_i;
					step_nxt = 2'h0;
					fin = 1'b1;
					unique case (cmd_i.op)
						OP_WRITE_REG:
						begin
							unique case (cmd_i.sel)
								SEL_WORKING: working_reg_nxt = cmd_i.data;
								SEL_FIRST_OFS: first_offset_reg_nxt = cmd_i.data;
								SEL_SECOND_OFS: second_offset_reg_nxt = cmd_i.data;
								SEL_FRAME_TOP: frame_top_ptr_nxt = cmd_i.data;
								SEL_FLAGS: flag_word_nxt = cmd_i.data;
								SEL_FETCH_LOW: fetch_pointer_nxt[7:0] = cmd_i.data;
								SEL_FETCH_HIGH: fetch_pointer_nxt[15:8] = cmd_i.data;
								default: fin = 1'b1;
							endcase
						end
						OP_INC_IDX, OP_DEC_IDX, OP_CMP_IDX:
						begin
							if (cmd_i.op != OP_CMP_IDX)
							begin
								if (use_second)
									second_offset_reg_nxt = idx_result;
								else
									first_offset_reg_nxt = idx_result;
							end
							flag_word_nxt[FLAG_N] = idx_flags.n;
							flag_word_nxt[FLAG_Z] = idx_flags.z;
							if (cmd_i.op == OP_CMP_IDX)
								flag_word_nxt[FLAG_C] = idx_flags.c;
						end
						OP_IDX_TO_WORKING: working_reg_nxt = idx_sel;
						OP_WORKING_TO_IDX:
						begin
							if (use_second)
								second_offset_reg_nxt = working_reg_r;
							else
								first_offset_reg_nxt = working_reg_r;
						end
						OP_IRQ, OP_SOFTWARE_BREAK:
						begin
							flag_snap_nxt = flag_word_r;
							flag_word_nxt[FLAG_I] = 1'b1;
							fin = 1'b0;
							state_nxt = ST_PUSH;
						end
						OP_CALL, OP_PUSH_WORKING, OP_PUSH_FLAGS:
						begin
							fin = 1'b0;
							state_nxt = ST_PUSH;
						end
						OP_RETURN_FROM_IRQ, OP_RETURN_FROM_SUB, OP_PULL_WORKING, OP_PULL_FLAGS:
						begin
							fin = 1'b0;
							state_nxt = ST_PULL;
						end
						OP_IDX_READ:
						begin
							mem_nxt.re = 1'b1;
							mem_nxt.addr = idx_addr;
							dest_nxt = DST_DATA;
							fin = 1'b0;
							state_nxt = ST_WAIT;
						end
						OP_IDX_WRITE:
						begin
							mem_nxt.we = 1'b1;
							mem_nxt.addr = idx_addr;
							mem_nxt.wdata = cmd_i.data;
						end
						OP_FETCH:
						begin
							fin = 1'b0;
							state_nxt = ST_FETCH;
						end
						default: fin = 1'b1;
					endcase
				end
			end
			ST_PUSH:
			begin
				mem_nxt.we = 1'b1;
				mem_nxt.addr = stack_addr;
				mem_nxt.wdata = push_byte;
				frame_top_ptr_nxt = frame_top_ptr_r - BYTE_ONE;
				step_nxt = step_r + STEP_ONE;
				if (push_last)
				begin
					if (cur_r.op == OP_IRQ || cur_r.op == OP_SOFTWARE_BREAK || cur_r.op == OP_CALL)
						fetch_pointer_nxt = cur_r.addr;
					fin = 1'b1;
				end
			end
			ST_PULL:
			begin
				frame_top_ptr_nxt = frame_up;
				mem_nxt.re = 1'b1;
				mem_nxt.addr = stack_addr_up;
				dest_nxt = pull_dest(cur_r.op, step_r);
				state_nxt = ST_WAIT;
			end
			ST_WAIT: state_nxt = ST_CAP;
			ST_CAP:
			begin
				unique case (dest_r)
					DST_WORKING: working_reg_nxt = mem_rdata_i;
					DST_FLAGS: flag_word_nxt = mem_rdata_i;
					DST_FETCH_LOW: fetch_pointer_nxt[7:0] = mem_rdata_i;
					DST_FETCH_HIGH: fetch_pointer_nxt[15:8] = mem_rdata_i;
					DST_OPCODE:
					begin
						opcode_nxt = mem_rdata_i;
						opcode_valid_nxt = 1'b1;
					end
					DST_DATA:
					begin
						rdata_nxt = mem_rdata_i;
						rdata_valid_nxt = 1'b1;
					end
					default: opcode_valid_nxt = 1'b0;
				endcase
				if (dest_r == DST_OPCODE)
				begin
					done_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
				else if (dest_r == DST_DATA || pull_last)
					fin = 1'b1;
				else
				begin
					step_nxt = step_r + STEP_ONE;
					state_nxt = ST_PULL;
				end
			end
			ST_FETCH:
			begin
				mem_nxt.re = 1'b1;
				mem_nxt.addr = fetch_pointer_r;
				fetch_pointer_nxt = fetch_pointer_r + PTR_ONE;
				dest_nxt = DST_OPCODE;
				state_nxt = ST_WAIT;
			end
		endcase
		// an ended instruction is followed by the next fetch
		if (fin)
		begin
			if (end_instr)
				state_nxt = ST_FETCH;
			else
			begin
				done_nxt = 1'b1;
				state_nxt = ST_IDLE;
			end
		end
		// ready registered from the next state so the port comes from a flop
		ready_nxt = (state_nxt == ST_IDLE);
	end

	// =====================================================================
	// state registers, frozen while ce_i is low
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= ST_IDLE;
			cur_r <= '0;
			dest_r <= DST_WORKING;
			step_r <= 2'h0;
			working_reg_r <= BYTE_RESET;
			first_offset_reg_r <= BYTE_RESET;
			second_offset_reg_r <= BYTE_RESET;
			frame_top_ptr_r <= BYTE_RESET;
			flag_word_r <= FLAG_RESET;
			flag_snap_r <= FLAG_RESET;
			fetch_pointer_r <= PTR_RESET;
			mem_r <= '0;
			done_r <= 1'b0;
			ready_r <= 1'b1;
			opcode_r <= BYTE_RESET;
			opcode_valid_r <= 1'b0;
			rdata_r <= BYTE_RESET;
			rdata_valid_r <= 1'b0;
		end
		else if (ce_i)
		begin
			state_r <= state_nxt;
			cur_r <= cur_nxt;
			dest_r <= dest_nxt;
			step_r <= step_nxt;
			working_reg_r <= working_reg_nxt;
			first_offset_reg_r <= first_offset_reg_nxt;
			second_offset_reg_r <= second_offset_reg_nxt;
			frame_top_ptr_r <= frame_top_ptr_nxt;
			flag_word_r <= flag_word_nxt;
			flag_snap_r <= flag_snap_nxt;
			fetch_pointer_r <= fetch_pointer_nxt;
			mem_r <= mem_nxt;
			done_r <= done_nxt;
			ready_r <= ready_nxt;
			opcode_r <= opcode_nxt;
			opcode_valid_r <= opcode_valid_nxt;
			rdata_r <= rdata_nxt;
			rdata_valid_r <= rdata_valid_nxt;
		end
	end

	// =====================================================================
	// outputs straight from flops
	assign cmd_ready_o = ready_r;
	assign done_o = done_r;
	assign mem_o = mem_r;
	assign opcode_o = opcode_r;
	assign opcode_valid_o = opcode_valid_r;
	assign rdata_o = rdata_r;
	assign rdata_valid_o = rdata_valid_r;
	assign working_reg_o = working_reg_r;
	assign first_offset_reg_o = first_offset_reg_r;
	assign second_offset_reg_o = second_offset_reg_r;
	assign frame_top_ptr_o = frame_top_ptr_r;
	assign flag_word_o = flag_word_r;
	assign fetch_pointer_o = fetch_pointer_r;

endmodule // cpu_regs_stack

// File: cpu_regs_pkg.sv
// shared types and constants for the cpu register file and stack sequencer
package cpu_regs_pkg;

	// =====================================================================
	// widths
	localparam int BYTE_W = 8;
	localparam int PTR_W = 16;

	// =====================================================================
	// flag word bit positions and reset value
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_I = 2;
	localparam int FLAG_B = 4;
	localparam int FLAG_N = 7;
	localparam logic [7:0] FLAG_RESET = 8'h04;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] PTR_RESET = 16'h0000;

	// =====================================================================
	// stack step counts and unit constants
	localparam logic [1:0] IRQ_PUSH_CNT = 2'h3;
	localparam logic [1:0] CALL_PUSH_CNT = 2'h2;
	localparam logic [1:0] ONE_PUSH_CNT = 2'h1;
	localparam logic [1:0] RTI_PULL_CNT = 2'h3;
	localparam logic [1:0] RTS_PULL_CNT = 2'h2;
	localparam logic [1:0] ONE_PULL_CNT = 2'h1;
	localparam logic [1:0] STEP_ONE = 2'h1;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [15:0] PTR_ONE = 16'h0001;
	localparam logic [6:0] PAGE_PAD = 7'h00;

	// =====================================================================
	// commands from instruction execution
	typedef enum logic [4:0] {
		OP_NOP,
		OP_WRITE_REG,
		OP_INC_IDX,
		OP_DEC_IDX,
		OP_CMP_IDX,
		OP_IDX_TO_WORKING,
		OP_WORKING_TO_IDX,
		OP_IRQ,
		OP_SOFTWARE_BREAK,
		OP_CALL,
		OP_RETURN_FROM_IRQ,
		OP_RETURN_FROM_SUB,
		OP_PUSH_WORKING,
		OP_PUSH_FLAGS,
		OP_PULL_WORKING,
		OP_PULL_FLAGS,
		OP_IDX_READ,
		OP_IDX_WRITE,
		OP_FETCH
	} cmd_op_e;

	typedef enum logic [2:0] {
		SEL_WORKING,
		SEL_FIRST_OFS,
		SEL_SECOND_OFS,
		SEL_FRAME_TOP,
		SEL_FLAGS,
		SEL_FETCH_LOW,
		SEL_FETCH_HIGH
	} reg_sel_e;

	typedef enum logic [1:0] {
		IDX_INC,
		IDX_DEC,
		IDX_CMP,
		IDX_PASS
	} idx_op_e;

	typedef enum logic [2:0] {
		DST_WORKING,
		DST_FLAGS,
		DST_FETCH_LOW,
		DST_FETCH_HIGH,
		DST_OPCODE,
		DST_DATA
	} dest_e;

	typedef struct packed {
		cmd_op_e op;
		reg_sel_e sel;
		logic [7:0] data;
		logic [15:0] addr;
		logic end_instr;
	} cmd_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} mem_s;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
	} idx_flags_s;

endpackage

// File: index_unit.sv
// index register arithmetic and indexed address forming
`timescale 1ns/1ps

module index_unit
	import cpu_regs_pkg::*;
(
	input wire logic [7:0] idx_i,
	input wire logic [7:0] operand_i,
	input wire logic [15:0] base_i,
	input wire idx_op_e op_i,
	output logic [7:0] result_o,
	output idx_flags_s flags_o,
	output logic [15:0] addr_o
);

	// =====================================================================
	// arithmetic
	logic [8:0] diff;
	logic [7:0] inc_val;
	logic [7:0] dec_val;
	logic [7:0] flag_src;

	assign diff = {1'b0, idx_i} - {1'b0, operand_i};
	assign inc_val = idx_i + BYTE_ONE;
	assign dec_val = idx_i - BYTE_ONE;

	// result and flag source per operation
	assign result_o = (op_i == IDX_INC) ? inc_val : (op_i == IDX_DEC) ? dec_val : idx_i;
	assign flag_src = (op_i == IDX_CMP) ? diff[7:0] : result_o;
	assign flags_o.n = flag_src[7];
	assign flags_o.z = (flag_src == BYTE_RESET);
	assign flags_o.c = (op_i == IDX_CMP) ? ~diff[8] : 1'b0; // no borrow sets carry

	// indexed address: operand address plus index
	assign addr_o = base_i + {BYTE_RESET, idx_i};

endmodule // index_unit

// File: cpu_regs_stack_props.sv
// port assertions for the cpu register and stack sequencer
`timescale 1ns/1ps

module cpu_regs_stack_props
	import cpu_regs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cmd_valid_i,
	input wire cmd_s cmd_i,
	input wire logic stack_page_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic cmd_ready_o,
	input wire logic done_o,
	input wire mem_s mem_o,
	input wire logic [7:0] opcode_o,
	input wire logic opcode_valid_o,
	input wire logic [7:0] rdata_o,
	input wire logic rdata_valid_o,
	input wire logic [7:0] working_reg_o,
	input wire logic [7:0] first_offset_reg_o,
	input wire logic [7:0] second_offset_reg_o,
	input wire logic [7:0] frame_top_ptr_o,
	input wire logic [7:0] flag_word_o,
	input wire logic [15:0] fetch_pointer_o
);
	// =====================================================================
	// helpers
	logic take;
	logic [15:0] fp_r;
	logic [7:0] s_r;
	logic idxw_r;
	assign take = cmd_valid_i && cmd_ready_o && ce_i;

	// pointers and kind held from the accepted command
	always_ff @(posedge clk_i)
	begin
		if (take)
		begin
			fp_r <= fetch_pointer_o;
			s_r <= frame_top_ptr_o;
			idxw_r <= cmd_i.op == OP_IDX_WRITE;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// =====================================================================
	// assertions
	chk_reset_mask: assert property ($fell(rst_i) |-> flag_word_o[FLAG_I])
		else $error("mask flag clear after reset");
	chk_irq_mask: assert property (take && cmd_i.op inside {OP_IRQ, OP_SOFTWARE_BREAK} |=> flag_word_o[FLAG_I])
		else $error("mask flag not set on entry");
	chk_irq_order: assert property (take && cmd_i.op == OP_IRQ |-> ##2 (mem_o.we && mem_o.wdata == fp_r[15:8])
		##1 (mem_o.we && mem_o.wdata == fp_r[7:0]) ##1 (mem_o.we && !mem_o.wdata[FLAG_B]))
		else $error("interrupt stacking order wrong");
	chk_break_src: assert property (take && cmd_i.op == OP_SOFTWARE_BREAK |-> ##4 mem_o.we && mem_o.wdata[FLAG_B])
		else $error("break flag not stacked");
	chk_call_push: assert property (take && cmd_i.op == OP_CALL |-> ##2 mem_o.we
		##1 (mem_o.we && mem_o.wdata == fp_r[7:0]) ##1 !mem_o.we)
		else $error("call push sequence wrong");
	chk_push_addr: assert property (mem_o.we && !idxw_r
		|-> mem_o.addr == {PAGE_PAD, stack_page_i, frame_top_ptr_o + BYTE_ONE})
		else $error("stack write address wrong");
	chk_push_work: assert property (take && cmd_i.op == OP_PUSH_WORKING
		|-> ##2 mem_o.we && mem_o.wdata == $past(working_reg_o, 2) && mem_o.addr[7:0] == s_r)
		else $error("working push wrong");
	chk_rti_pull: assert property (take && cmd_i.op == OP_RETURN_FROM_IRQ
		|-> ##2 (mem_o.re && mem_o.addr[7:0] == s_r + BYTE_ONE) ##3 (mem_o.re && mem_o.addr[7:0] == s_r + 8'h02)
		##3 (mem_o.re && mem_o.addr[7:0] == s_r + 8'h03))
		else $error("interrupt return pulls wrong");
	chk_rti_done: assert property (take && cmd_i.op == OP_RETURN_FROM_IRQ && !cmd_i.end_instr
		|=> !done_o [*8] ##2 done_o)
		else $error("interrupt return length wrong");
	chk_pull_load: assert property (take && cmd_i.op == OP_PULL_WORKING && !cmd_i.end_instr
		|-> ##4 working_reg_o == $past(mem_rdata_i))
		else $error("working pull wrong");
	chk_fetch_data: assert property (opcode_valid_o |-> opcode_o == $past(mem_rdata_i))
		else $error("opcode not from memory");
	chk_idx_data: assert property (rdata_valid_o |-> rdata_o == $past(mem_rdata_i))
		else $error("indexed read data wrong");

	// main scenarios
	cov_irq: cover property (take && cmd_i.op == OP_IRQ);
	cov_rti: cover property (take && cmd_i.op == OP_RETURN_FROM_IRQ);
	cov_wrap: cover property (mem_o.we && frame_top_ptr_o == 8'hFF);
	cov_fetch: cover property (opcode_valid_o);
endmodule // cpu_regs_stack_props

bind cpu_regs_stack cpu_regs_stack_props chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .stack_page_i(stack_page_i), .mem_rdata_i(mem_rdata_i),
	.cmd_ready_o(cmd_ready_o), .done_o(done_o), .mem_o(mem_o), .opcode_o(opcode_o),
	.opcode_valid_o(opcode_valid_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
	.working_reg_o(working_reg_o), .first_offset_reg_o(first_offset_reg_o),
	.second_offset_reg_o(second_offset_reg_o), .frame_top_ptr_o(frame_top_ptr_o),
	.flag_word_o(flag_word_o), .fetch_pointer_o(fetch_pointer_o));

// File: stack_mem_model.sv
// behavioural program and stack memory beside the sequencer
`timescale 1ns/1ps

module stack_mem_model
	import cpu_regs_pkg::*;
(
	input wire logic clk_i,
	input wire mem_s mem_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:65535];

	// address pattern fill so every read is known
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
		rdata_o = 8'h00;
	end

	// write on the strobe, data one cycle after a read strobe, otherwise toggling
	always @(posedge clk_i)
	begin
		if (mem_i.we)
			mem[mem_i.addr] <= mem_i.wdata;
		rdata_o <= mem_i.re ? mem[mem_i.addr] : ~rdata_o;
	end
endmodule // stack_mem_model

// File: cpu_regs_stack_tb.sv
// self-checking bench for the cpu register and stack sequencer
`timescale 1ns/1ps

module cpu_regs_stack_tb
	import cpu_regs_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic cmd_valid_i = 1'b0;
	logic stack_page_i = 1'b0;
	cmd_s cmd_i = '0;
	logic [7:0] mem_rdata_i, opcode_o, rdata_o, working_reg_o, first_offset_reg_o;
	logic [7:0] second_offset_reg_o, frame_top_ptr_o, flag_word_o;
	logic cmd_ready_o, done_o, opcode_valid_o, rdata_valid_o;
	logic [15:0] fetch_pointer_o;
	mem_s mem_o;
	int bad_count = 0;
	int cmp_count = 0;
	int seed = 32'h81c25a54;
	// expected state
	logic [7:0] a = 8'h00, x = 8'h00, y = 8'h00, s = 8'h00, p = FLAG_RESET, ex_rd, ex_op;
	logic [15:0] pc = 16'h0000;
	logic [7:0] sh [int];

	// =====================================================================
	// design, memory and clock
	cpu_regs_stack uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
		.stack_page_i(stack_page_i), .mem_rdata_i(mem_rdata_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
		.mem_o(mem_o), .opcode_o(opcode_o), .opcode_valid_o(opcode_valid_o), .rdata_o(rdata_o),
		.rdata_valid_o(rdata_valid_o), .working_reg_o(working_reg_o), .first_offset_reg_o(first_offset_reg_o),
		.second_offset_reg_o(second_offset_reg_o), .frame_top_ptr_o(frame_top_ptr_o),
		.flag_word_o(flag_word_o), .fetch_pointer_o(fetch_pointer_o));
	stack_mem_model mem_m (.clk_i(clk_i), .mem_i(mem_o), .rdata_o(mem_rdata_i));

	initial
		forever #4 clk_i = ~clk_i;

	// =====================================================================
	// expectation helpers
	function automatic logic [7:0] rd(logic [15:0] ad);
		return sh.exists(ad) ? sh[ad] : ad[7:0] ^ ad[15:8] ^ 8'h5A;
	endfunction

	function automatic logic [15:0] sa(logic [7:0] v);
		return {PAGE_PAD, stack_page_i, v};
	endfunction

	function automatic void push(logic [7:0] v);
		sh[sa(s)] = v;
		s = s - 8'h01;
	endfunction

	function automatic logic [7:0] pull();
		s = s + 8'h01;
		return rd(sa(s));
	endfunction

	function automatic void nz(logic [7:0] v);
		p[FLAG_N] = v[7];
		p[FLAG_Z] = v == 8'h00;
	endfunction

	// expected effect of one command
	function automatic void model(cmd_s c);
		logic sb;
		logic [7:0] ix;
		logic [7:0] r;
		logic [15:0] ia;
		sb = c.sel == SEL_SECOND_OFS;
		ix = sb ? y : x;
		r = ix;
		ia = c.addr + {8'h00, ix};
		case (c.op)
			OP_WRITE_REG:
				case (c.sel)
					SEL_WORKING: a = c.data;
					SEL_FIRST_OFS: x = c.data;
					SEL_SECOND_OFS: y = c.data;
					SEL_FRAME_TOP: s = c.data;
					SEL_FLAGS: p = c.data;
					SEL_FETCH_LOW: pc[7:0] = c.data;
					default: pc[15:8] = c.data;
				endcase
			OP_INC_IDX: r = ix + 8'h01;
			OP_DEC_IDX: r = ix - 8'h01;
			OP_CMP_IDX: p[FLAG_C] = ix >= c.data;
			OP_IDX_TO_WORKING: a = ix;
			OP_WORKING_TO_IDX: r = a;
			OP_IRQ, OP_SOFTWARE_BREAK, OP_CALL:
			begin
				push(pc[15:8]);
				push(pc[7:0]);
				if (c.op != OP_CALL)
					push({p[7:5], c.op == OP_SOFTWARE_BREAK, p[3:0]});
				if (c.op != OP_CALL)
					p[FLAG_I] = 1'b1;
				pc = c.addr;
			end
			OP_RETURN_FROM_IRQ, OP_RETURN_FROM_SUB:
			begin
				if (c.op == OP_RETURN_FROM_IRQ)
					p = pull();
				pc[7:0] = pull();
				pc[15:8] = pull();
			end
			OP_PUSH_WORKING: push(a);
			OP_PUSH_FLAGS: push(p);
			OP_PULL_WORKING: a = pull();
			OP_PULL_FLAGS: p = pull();
			OP_IDX_READ: ex_rd = rd(ia);
			OP_IDX_WRITE: sh[ia] = c.data;
			default: ;
		endcase
		if (c.op inside {OP_INC_IDX, OP_DEC_IDX, OP_WORKING_TO_IDX})
		begin
			if (sb)
				y = r;
			else
				x = r;
		end
		if (c.op inside {OP_INC_IDX, OP_DEC_IDX})
			nz(r);
		if (c.op == OP_CMP_IDX)
			nz(ix - c.data);
		if (c.end_instr || c.op == OP_FETCH)
		begin
			ex_op = rd(pc);
			pc = pc + 16'h0001;
		end
	endfunction

	// =====================================================================
	// compare, command driver and verdict
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic run(input cmd_s c);
		int n;
		n = 0;
		@(negedge clk_i);
		ce_i = c.data[0];
		stack_page_i = c.addr[4];
		@(negedge clk_i);
		ce_i = 1'b1;
		cmd_i = c;
		cmd_valid_i = 1'b1;
		chk({15'h0000, cmd_ready_o}, 16'h0001);
		@(posedge clk_i);
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		while (done_o !== 1'b1 && n < 64)
		begin
			n++;
			@(negedge clk_i);
		end
		chk({15'h0000, done_o}, 16'h0001);
		model(c);
		chk({8'h00, working_reg_o}, {8'h00, a});
		chk({first_offset_reg_o, second_offset_reg_o}, {x, y});
		chk({8'h00, frame_top_ptr_o}, {8'h00, s});
		chk({8'h00, flag_word_o}, {8'h00, p});
		chk(fetch_pointer_o, pc);
		if (c.op == OP_IDX_READ)
			chk({8'h00, rdata_o}, {8'h00, ex_rd});
		if (c.end_instr || c.op == OP_FETCH)
			chk({8'h00, opcode_o}, {8'h00, ex_op});
	endtask

	task automatic print_verdict();
		if (bad_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// hang guard
	initial
	begin
		#400000;
		bad_count++;
		$display("MISMATCH %0t watchdog expired", $time);
		print_verdict();
	end

	// =====================================================================
	// reset, corner cases, every command code, then random traffic
	initial
	begin
		cmd_s c;
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		chk({8'h00, flag_word_o}, {8'h00, FLAG_RESET});
		run('{OP_WRITE_REG, SEL_FRAME_TOP, 8'h01, 16'h0010, 1'b0});
		run('{OP_PUSH_WORKING, SEL_WORKING, 8'h00, 16'h0010, 1'b0});
		run('{OP_PUSH_FLAGS, SEL_WORKING, 8'h01, 16'h0010, 1'b0});
		run('{OP_PULL_WORKING, SEL_WORKING, 8'h00, 16'h0010, 1'b0});
		run('{OP_IRQ, SEL_WORKING, 8'h00, 16'h1234, 1'b1});
		run('{OP_RETURN_FROM_IRQ, SEL_WORKING, 8'h01, 16'h0010, 1'b0});
		run('{OP_SOFTWARE_BREAK, SEL_WORKING, 8'h01, 16'h0010, 1'b0});
		run('{OP_CALL, SEL_WORKING, 8'h00, 16'hABCD, 1'b1});
		run('{OP_RETURN_FROM_SUB, SEL_WORKING, 8'h01, 16'h0000, 1'b1});
		run('{OP_WRITE_REG, SEL_SECOND_OFS, 8'hFF, 16'h0000, 1'b0});
		run('{OP_IDX_WRITE, SEL_SECOND_OFS, 8'hC3, 16'hFF80, 1'b0});
		run('{OP_IDX_READ, SEL_SECOND_OFS, 8'h00, 16'hFF80, 1'b0});
		for (int i = 0; i < 19; i++)
			run('{cmd_op_e'(i), SEL_SECOND_OFS, 8'hFF, 16'hFFF0, 1'b0});
		repeat (400)
		begin
			c.op = cmd_op_e'($unsigned($random(seed)) % 19);
			c.sel = reg_sel_e'($unsigned($random(seed)) % 7);
			c.data = 8'($random(seed));
			c.addr = 16'($random(seed));
			c.end_instr = c.op != OP_FETCH && c.data[2:1] == 2'h0;
			run(c);
		end
		print_verdict();
	end
endmodule // cpu_regs_stack_tb
